// ==== logic/sai_pkg.sv ====
// shared constants of the stack and indirect addressing unit
package sai_pkg;
  // register word indices (byte address is four times the index)
  localparam logic [11:0] IDX_IND0   = 12'h000;
  localparam logic [11:0] IDX_IND1   = 12'h001;
  localparam logic [11:0] IDX_PTR0_L = 12'h004;
  localparam logic [11:0] IDX_PTR0_H = 12'h005;
  localparam logic [11:0] IDX_PTR1_L = 12'h006;
  localparam logic [11:0] IDX_PTR1_H = 12'h007;
  localparam logic [11:0] IDX_SIDX   = 12'hfed;
  localparam logic [11:0] IDX_TOP_L  = 12'hfee;
  localparam logic [11:0] IDX_TOP_H  = 12'hfef;
  localparam logic [11:0] IDX_CTL    = 12'hff0;
  // control register bits
  localparam int CTL_EN  = 0;
  localparam int CTL_OVF = 1;
  localparam int CTL_UNF = 2;
  // stack geometry
  localparam int          PC_W     = 15;
  localparam int          PW_W     = 14;
  localparam int          STK_N    = 16;
  localparam logic [4:0]  SP_EMPTY = 5'h1f;
  localparam logic [4:0]  SP_TOP   = 5'h0f;
  localparam logic [4:0]  SP_WRAP  = 5'h0e;
  localparam logic [15:0] PTR_RST  = 16'h0000;
  // pointer regions
  localparam logic [3:0]  LIN_HI   = 4'h2;
  localparam logic [11:0] LIN_LAST = 12'hfef;
  localparam logic [11:0] GPR_LEN  = 12'h050;
  localparam logic [6:0]  GPR_OFS  = 7'h20;
  // access sequencer
  typedef enum logic [2:0] {
    SAI_IDLE  = 3'b000,
    SAI_ISSUE = 3'b001,
    SAI_WAIT  = 3'b011,
    SAI_HOLD  = 3'b010,
    SAI_ACK   = 3'b110
  } sai_st_t;
endpackage

// ==== logic/sai_core.sv ====
// return-address stack and indirect pointer unit with wishbone registers
`timescale 1ns/1ps
module sai_core
  import sai_pkg::*;
#(
  parameter int BANKS = 32
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic [13:0]     wb_adr_i,
  input  wire logic [31:0]     wb_dat_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic            wb_we_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  output logic [31:0]          wb_dat_o,
  output logic                 wb_ack_o,
  input  wire logic            push_i,
  input  wire logic [PC_W-1:0] push_pc_i,
  input  wire logic            pop_i,
  output logic [PC_W-1:0]      pop_pc_o,
  output logic                 dev_reset_o,
  output logic                 mem_req_o,
  output logic                 mem_we_o,
  output logic [12:0]          mem_adr_o,
  output logic [7:0]           mem_wdat_o,
  input  wire logic [7:0]      mem_rdat_i,
  output logic                 fl_req_o,
  output logic [PC_W-1:0]      fl_adr_o,
  input  wire logic [PW_W-1:0] fl_rdat_i
);

  // ************************************************************
  // pointer decode
  // ************************************************************

  // returns {target ok, flash, 15-bit target address}
  function automatic logic [16:0] sai_map(input logic [15:0] p);
    logic [11:0] o;
    logic [11:0] bk;
    logic [11:0] rm;
    o  = p[11:0];
    bk = o / GPR_LEN;
    rm = o - bk * GPR_LEN;
    if (p[15]) begin
      sai_map = {2'b11, p[14:0]};
    end else if (p[15:13] == 3'b000) begin
      sai_map = {(32'(p[12:7]) < BANKS) && (p[6:1] != 6'h00), 1'b0, 2'b00, p[12:0]};
    end else if (p[15:12] == LIN_HI && o <= LIN_LAST && 32'(bk) < BANKS) begin
      // common ram never reached: offset stays below 0x70
      sai_map = {2'b10, 2'b00, bk[5:0], GPR_OFS + rm[6:0]};
    end else begin
      sai_map = 17'h00000;
    end
  endfunction

  // ************************************************************
  // state and decode
  // ************************************************************

  sai_st_t          st_q;
  logic             ack_q;
  logic [31:0]      dat_q;
  logic [15:0]      ptr0_q;
  logic [15:0]      ptr1_q;
  logic [4:0]       sp_q;
  logic             en_q;
  logic             ovf_q;
  logic             unf_q;
  logic             rst_req_q;
  logic [PC_W-1:0]  pop_q;
  logic [PC_W-1:0]  stk_q [STK_N];
  logic             ok_q;
  logic             fl_q;
  logic             mreq_q;
  logic             mwe_q;
  logic [12:0]      madr_q;
  logic [7:0]       mwd_q;
  logic             freq_q;
  logic [PC_W-1:0]  fadr_q;
  logic             acc;
  logic             wr;
  logic [11:0]      idx;
  logic             is_ind;
  logic [15:0]      ptr_sel;
  logic [16:0]      tgt;
  logic [PC_W-1:0]  top_rd;
  logic [31:0]      rd_mux;
  logic             sp_top;
  logic             sp_emp;
  logic             do_push;
  logic [3:0]       push_slot;

  assign acc     = wb_cyc_i && wb_stb_i && !ack_q && (st_q == SAI_IDLE);
  assign wr      = acc && wb_we_i && wb_sel_i[0];
  assign idx     = wb_adr_i[13:2];
  assign is_ind  = (idx == IDX_IND0) || (idx == IDX_IND1);
  assign ptr_sel = idx[0] ? ptr1_q : ptr0_q;
  assign tgt     = sai_map(ptr_sel);
  assign sp_top  = (sp_q == SP_TOP);
  assign sp_emp  = (sp_q == SP_EMPTY);

  // overflowing push with fault reset stores nothing
  assign do_push   = push_i && !(sp_top && en_q);
  assign push_slot = sp_top ? 4'h0 : 4'(sp_q + 5'h01);

  // empty stack shows zero or the highest slot
  assign top_rd = (sp_emp && en_q) ? '0 : stk_q[sp_q[3:0]];

  // plain register read mux; unmapped words read zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (idx == IDX_PTR0_L) begin
      rd_mux[7:0] = ptr0_q[7:0];
    end else if (idx == IDX_PTR0_H) begin
      rd_mux[7:0] = ptr0_q[15:8];
    end else if (idx == IDX_PTR1_L) begin
      rd_mux[7:0] = ptr1_q[7:0];
    end else if (idx == IDX_PTR1_H) begin
      rd_mux[7:0] = ptr1_q[15:8];
    end else if (idx == IDX_SIDX) begin
      rd_mux[4:0] = sp_q;
    end else if (idx == IDX_TOP_L) begin
      rd_mux[7:0] = top_rd[7:0];
    end else if (idx == IDX_TOP_H) begin
      rd_mux[6:0] = top_rd[14:8];
    end else if (idx == IDX_CTL) begin
      rd_mux[2:0] = {unf_q, ovf_q, en_q};
    end
  end

  // ************************************************************
  // bus sequencer
  // ************************************************************

  // plain words answer next cycle; indirect ones walk issue and wait
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q  <= SAI_IDLE;
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
      ok_q  <= 1'b0;
      fl_q  <= 1'b0;
    end else begin
      case (st_q)
        SAI_IDLE: begin
          if (acc && is_ind) begin
            st_q <= SAI_ISSUE;
            ok_q <= tgt[16];
            fl_q <= tgt[15];
          end else if (acc) begin
            st_q  <= SAI_ACK;
            ack_q <= 1'b1;
            dat_q <= rd_mux;
          end
        end
        SAI_ISSUE: begin
          st_q <= SAI_WAIT;
        end
        SAI_WAIT: begin
          // data from either store arrives one cycle after the request
          if (!ok_q) begin
            dat_q <= 32'h00000000;
          end else if (fl_q) begin
            dat_q <= {24'h000000, fl_rdat_i[7:0]};
          end else begin
            dat_q <= {24'h000000, mem_rdat_i};
          end
          if (fl_q) begin
            st_q <= SAI_HOLD;
          end else begin
            st_q  <= SAI_ACK;
            ack_q <= 1'b1;
          end
        end
        SAI_HOLD: begin
          st_q  <= SAI_ACK;
          ack_q <= 1'b1;
        end
        default: begin
          st_q  <= SAI_IDLE;
          ack_q <= 1'b0;
        end
      endcase
    end
  end

  // one-cycle request toward data memory or flash
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mreq_q <= 1'b0;
      mwe_q  <= 1'b0;
      madr_q <= '0;
      mwd_q  <= 8'h00;
      freq_q <= 1'b0;
      fadr_q <= '0;
    end else begin
      mreq_q <= 1'b0;
      freq_q <= 1'b0;
      mwe_q  <= 1'b0;
      if (st_q == SAI_IDLE && acc && is_ind && tgt[16]) begin
        if (tgt[15]) begin
          // no write path into flash exists
          freq_q <= !wb_we_i;
          fadr_q <= tgt[14:0];
        end else if (!wb_we_i || wb_sel_i[0]) begin
          mreq_q <= 1'b1;
          mwe_q  <= wb_we_i;
          madr_q <= tgt[12:0];
          mwd_q  <= wb_dat_i[7:0];
        end
      end
    end
  end

  // ************************************************************
  // pointer registers
  // ************************************************************

  // byte writes assemble each pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr0_q <= PTR_RST;
      ptr1_q <= PTR_RST;
    end else if (wr) begin
      if (idx == IDX_PTR0_L) ptr0_q[7:0]  <= wb_dat_i[7:0];
      if (idx == IDX_PTR0_H) ptr0_q[15:8] <= wb_dat_i[7:0];
      if (idx == IDX_PTR1_L) ptr1_q[7:0]  <= wb_dat_i[7:0];
      if (idx == IDX_PTR1_H) ptr1_q[15:8] <= wb_dat_i[7:0];
    end
  end

  // ************************************************************
  // stack pointer and faults
  // ************************************************************

  // hardware push and pop win over a software index write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_q      <= SP_EMPTY;
      en_q      <= 1'b0;
      ovf_q     <= 1'b0;
      unf_q     <= 1'b0;
      rst_req_q <= 1'b0;
      pop_q     <= '0;
    end else begin
      rst_req_q <= 1'b0;
      if (wr && idx == IDX_CTL) begin
        en_q <= wb_dat_i[CTL_EN];
        // write one clears; a fault below in the same cycle still sets
        if (wb_dat_i[CTL_OVF]) ovf_q <= 1'b0;
        if (wb_dat_i[CTL_UNF]) unf_q <= 1'b0;
      end
      if (push_i) begin
        if (sp_top) begin
          ovf_q <= 1'b1;
          if (en_q) begin
            sp_q      <= SP_EMPTY;
            rst_req_q <= 1'b1;
          end else begin
            sp_q <= 5'h00; // oldest entry is overwritten
          end
        end else begin
          sp_q <= sp_q + 5'h01;
        end
      end else if (pop_i) begin
        pop_q <= top_rd; // slot read before the decrement
        if (sp_emp) begin
          unf_q <= 1'b1;
          if (en_q) begin
            rst_req_q <= 1'b1;
          end else begin
            sp_q <= SP_WRAP;
          end
        end else if (sp_q == 5'h00) begin
          sp_q <= SP_EMPTY;
        end else begin
          sp_q <= sp_q - 5'h01;
        end
      end else if (wr && idx == IDX_SIDX) begin
        sp_q <= wb_dat_i[4:0];
      end
    end
  end

  // slot storage holds data only, so it needs no reset
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      stk_q[push_slot] <= push_pc_i;
    end else if (!push_i && !pop_i && wr && !(sp_emp && en_q)) begin
      if (idx == IDX_TOP_L) stk_q[sp_q[3:0]][7:0]  <= wb_dat_i[7:0];
      if (idx == IDX_TOP_H) stk_q[sp_q[3:0]][14:8] <= wb_dat_i[6:0];
    end
  end

  assign wb_ack_o    = ack_q;
  assign wb_dat_o    = dat_q;
  assign pop_pc_o    = pop_q;
  assign dev_reset_o = rst_req_q;
  assign mem_req_o   = mreq_q;
  assign mem_we_o    = mwe_q;
  assign mem_adr_o   = madr_q;
  assign mem_wdat_o  = mwd_q;
  assign fl_req_o    = freq_q;
  assign fl_adr_o    = fadr_q;

  // ************************************************************
  // assertions
  // ************************************************************

  sequence s_ind_acc;
    acc && is_ind;
  endsequence

  property p_empty_after_reset;
    @(posedge clk_i) rst_i |=> sp_q == SP_EMPTY;
  endproperty
  a_empty_after_reset: assert property (p_empty_after_reset)
    else $error("stack not empty after reset");

  property p_push_order;
    @(posedge clk_i) disable iff (rst_i)
      push_i && sp_q == 5'h03 |=> sp_q == 5'h04 && stk_q[4] == $past(push_pc_i);
  endproperty
  a_push_order: assert property (p_push_order)
    else $error("push did not pre-increment and store");

  property p_pop_order;
    @(posedge clk_i) disable iff (rst_i)
      pop_i && !push_i && sp_q == 5'h03 |=> sp_q == 5'h02 && pop_pc_o == $past(stk_q[3]);
  endproperty
  a_pop_order: assert property (p_pop_order)
    else $error("pop did not read then decrement");

  property p_fault_reset;
    @(posedge clk_i) disable iff (rst_i)
      push_i && sp_top && en_q |=> dev_reset_o && ovf_q ##1 !dev_reset_o;
  endproperty
  a_fault_reset: assert property (p_fault_reset)
    else $error("overflow did not give a one-cycle reset");

  property p_circular;
    @(posedge clk_i) disable iff (rst_i)
      push_i && sp_top && !en_q |=> sp_q == 5'h00 && ovf_q && !dev_reset_o;
  endproperty
  a_circular: assert property (p_circular)
    else $error("overflow did not wrap");

  property p_first_push;
    @(posedge clk_i) disable iff (rst_i) push_i && sp_emp |=> sp_q == 5'h00;
  endproperty
  a_first_push: assert property (p_first_push)
    else $error("first push missed slot zero");

  property p_mem_latency;
    @(posedge clk_i) disable iff (rst_i)
      s_ind_acc and !tgt[15] |-> !wb_ack_o [*3] ##1 wb_ack_o;
  endproperty
  a_mem_latency: assert property (p_mem_latency)
    else $error("data memory access answered off time");

  property p_flash_latency;
    @(posedge clk_i) disable iff (rst_i)
      s_ind_acc and tgt[15] |-> !wb_ack_o [*4] ##1 wb_ack_o;
  endproperty
  a_flash_latency: assert property (p_flash_latency)
    else $error("flash access lacks its extra cycle");

  property p_no_self;
    @(posedge clk_i) disable iff (rst_i)
      mem_req_o |-> mem_adr_o[6:1] != 6'h00 && !fl_req_o;
  endproperty
  a_no_self: assert property (p_no_self)
    else $error("access reached an indirect data register");

endmodule

// ==== sim/sai_cpu_model.sv ====
// data memory and program flash that answer the indirect unit
`timescale 1ns/1ps
module sai_cpu_model (
  input  wire logic        clk_i,
  input  wire logic        mem_req_i,
  input  wire logic        mem_we_i,
  input  wire logic [12:0] mem_adr_i,
  input  wire logic [7:0]  mem_wdat_i,
  output logic      [7:0]  mem_rdat_o,
  input  wire logic        fl_req_i,
  input  wire logic [14:0] fl_adr_i,
  output logic      [13:0] fl_rdat_o
);
  logic [7:0] mem_q [0:8191];
  initial begin
    mem_rdat_o = 8'h00;
    fl_rdat_o  = 14'h0000;
  end
  // answer one cycle after the request; idle cycles toggle so stale data never looks valid
  always @(posedge clk_i) begin
    if (mem_req_i && mem_we_i) begin
      mem_q[mem_adr_i] <= mem_wdat_i;
    end
    mem_rdat_o <= mem_req_i ? mem_q[mem_adr_i] : ~mem_rdat_o;
  end
  // flash word is a pure function of the address; no write path exists
  always @(posedge clk_i) begin
    fl_rdat_o <= fl_req_i ? {fl_adr_i[5:0], fl_adr_i[7:0] ^ 8'h5a} : ~fl_rdat_o;
  end
endmodule

// ==== sim/sai_core_tb_top.sv ====
// self-checking bench of the stack and indirect unit
`timescale 1ns/1ps
module sai_core_tb_top;
  import sai_pkg::*;
  logic clk_i, rst_i, we, cyc, stb, ack, push, pop, devr;
  logic mreq, mwe, freq;
  logic [13:0] adr;
  logic [31:0] wdat, rdat;
  logic [14:0] ppc, popc, fadr;
  logic [12:0] madr;
  logic [7:0]  mwd, mrd;
  logic [13:0] frd;
  int fail_count, comparisons, nreq, nrst, lm, lf;
  logic [12:0] last_adr;
  logic [14:0] last_fl;
  sai_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
    .wb_ack_o(ack), .push_i(push), .push_pc_i(ppc), .pop_i(pop), .pop_pc_o(popc),
    .dev_reset_o(devr), .mem_req_o(mreq), .mem_we_o(mwe), .mem_adr_o(madr),
    .mem_wdat_o(mwd), .mem_rdat_i(mrd), .fl_req_o(freq), .fl_adr_o(fadr),
    .fl_rdat_i(frd));
  sai_cpu_model mdl_u (.clk_i(clk_i), .mem_req_i(mreq), .mem_we_i(mwe),
    .mem_adr_i(madr), .mem_wdat_i(mwd), .mem_rdat_o(mrd), .fl_req_i(freq),
    .fl_adr_i(fadr), .fl_rdat_o(frd));
  // ****************
  // clock and monitors
  // ****************
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (mreq === 1'b1) begin
      nreq++;
      last_adr <= madr;
    end
    if (freq === 1'b1) last_fl <= fadr;
    if (devr === 1'b1) nrst++;
  end
  // ****************
  // tasks
  // ****************
  task automatic finish_test;
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // holds the request until ack is sampled; n counts edges waited
  task automatic wb(input logic w, input logic [11:0] i, input logic [7:0] d,
                    output logic [31:0] q, output int n);
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50) fail_count++;
  endtask
  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    logic [31:0] q;
    int n;
    wb(1'b1, i, d, q, n);
  endtask
  task automatic rd(input logic [11:0] i, input logic [7:0] e);
    logic [31:0] q;
    int n;
    wb(1'b0, i, 8'h00, q, n);
    chk(q, {24'h000000, e});
  endtask
  task automatic setp(input logic [11:0] lo, input logic [15:0] p);
    wr(lo + 12'h001, p[15:8]);
    wr(lo, p[7:0]);
  endtask
  task automatic psh(input logic [14:0] v);
    @(posedge clk_i);
    push <= 1'b1;
    ppc <= v;
    @(posedge clk_i);
    push <= 1'b0;
  endtask
  task automatic pp(input logic [14:0] e);
    @(posedge clk_i);
    pop <= 1'b1;
    @(posedge clk_i);
    pop <= 1'b0;
    @(posedge clk_i);
    chk({17'h00000, popc}, {17'h00000, e});
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_stack_wrap;
    for (int k = 0; k < 16; k++) psh(15'h0100 + 15'(k));
    rd(IDX_SIDX, 8'h0f);
    rd(IDX_TOP_H, 8'h01);
    psh(15'h0200);
    rd(IDX_SIDX, 8'h00);
    rd(IDX_CTL, 8'h02);
    pp(15'h0200);
    rd(IDX_SIDX, 8'h1f);
    rd(IDX_TOP_L, 8'h0f);
    pp(15'h010f);
    pp(15'h010e);
    rd(IDX_SIDX, 8'h0d);
    wr(IDX_SIDX, 8'h05);
    rd(IDX_TOP_L, 8'h05);
    wr(IDX_TOP_L, 8'h77);
    rd(IDX_TOP_L, 8'h77);
    // a pop from a mid-stack index reads its slot, then steps down
    wr(IDX_SIDX, 8'h03);
    pp(15'h0103);
    rd(IDX_SIDX, 8'h02);
    chk(nrst, 0);
  endtask
  task automatic t_stack_fault;
    wr(IDX_CTL, 8'h07);
    rd(IDX_CTL, 8'h01);
    wr(IDX_SIDX, 8'h1f);
    rd(IDX_TOP_L, 8'h00);
    for (int k = 0; k < 17; k++) psh(15'h0300 + 15'(k));
    // the reset pulse is counted one edge after the push, so read first
    rd(IDX_SIDX, 8'h1f);
    chk(nrst, 1);
    rd(IDX_CTL, 8'h03);
    pp(15'h0000);
    rd(IDX_CTL, 8'h07);
    chk(nrst, 2);
  endtask
  task automatic t_indirect;
    logic [31:0] q;
    int n;
    setp(IDX_PTR0_L, 16'h204f);
    wr(IDX_IND0, 8'h5c);
    chk(last_adr, 13'h006f);
    setp(IDX_PTR0_L, 16'h2050);
    wr(IDX_IND0, 8'h3c);
    chk(last_adr, 13'h00a0);
    wb(1'b0, IDX_IND0, 8'h00, q, lm);
    chk(q, 32'h0000003c);
    // common ram right after bank zero's block must not alias the linear byte
    setp(IDX_PTR1_L, 16'h0070);
    wr(IDX_IND1, 8'ha5);
    rd(IDX_IND0, 8'h3c);
    setp(IDX_PTR1_L, 16'h006f);
    rd(IDX_IND1, 8'h5c);
    chk(last_adr, 13'h006f);
    setp(IDX_PTR0_L, 16'h0081);
    n = nreq;
    wr(IDX_IND0, 8'h11);
    chk(nreq, n);
    rd(IDX_IND0, 8'h00);
    setp(IDX_PTR0_L, 16'h2fef);
    rd(IDX_IND0, 8'h00);
    setp(IDX_PTR0_L, 16'h8123);
    wb(1'b0, IDX_IND0, 8'h00, q, lf);
    chk(q, 32'h00000079);
    chk(last_fl, 15'h0123);
    chk(lf, lm + 1);
    n = nreq;
    wr(IDX_IND0, 8'h55);
    chk(nreq, n);
    rd(IDX_IND0, 8'h79);
  endtask
  // ****************
  // main sequence and watchdog
  // ****************
  initial begin
    {rst_i, we, cyc, stb, push, pop} = 6'b100000;
    {adr, wdat, ppc} = '0;
    {fail_count, comparisons, nreq, nrst} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_SIDX, 8'h1f);
    rd(IDX_PTR0_H, 8'h00);
    rd(IDX_CTL, 8'h00);
    t_stack_wrap();
    t_stack_fault();
    t_indirect();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    finish_test();
  end
endmodule
